// ### logic/asp_map.vh
// Register offsets, field positions and reset values of the serial port
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
`define ASP_OFF_DATA 5'h00
`define ASP_OFF_STAT 5'h04
`define ASP_OFF_CTL0 5'h08
`define ASP_OFF_CTL1 5'h0c
`define ASP_OFF_ADDR 5'h10
`define ASP_OFF_DIVH 5'h14
`define ASP_OFF_DIVL 5'h18
`define ASP_OFF_IRQ 5'h1c
`define ASP_C0_TXEN 7
`define ASP_C0_REN 6
`define ASP_C0_CTSE 5
`define ASP_C0_PEN 4
`define ASP_C0_PODD 3
`define ASP_C1_MPEN 7
`define ASP_C1_SCHEME_HI 6
`define ASP_C1_SCHEME_LO 5
`define ASP_C1_MARK 4
`define ASP_C1_TMREN 3
`define ASP_C1_ERRONLY 2
`define ASP_C1_RIE 1
`define ASP_C1_TIE 0
`define ASP_CTL0_RST 8'h00
`define ASP_CTL1_RST 8'h00
`define ASP_ADDR_RST 8'h00
`define ASP_DIV_RST 16'h0002
`define ASP_OVS_LAST 4'hf
`define ASP_MID_LAST 4'h7
`define ASP_MP_ALL 2'h0
`define ASP_MP_ADDR_ONLY 2'h1
`define ASP_MP_MATCH 2'h2
`define ASP_MP_MATCH_KEEP 2'h3
`endif

// ### logic/asp_rate_gen.v
// Rate generator: one-cycle tick every divisor clocks
`include "asp_map.vh"
module asp_rate_gen (
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire [15:0] rate_divisor,
	output reg tick_reg
);
	reg [15:0] cnt_reg;
	////////////////////////////////////////////////////////////////
	// Down counter reloads with divisor - 1 after each tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (!run) begin
			cnt_reg <= rate_divisor - 16'h0001; // RULE_13
			tick_reg <= 1'b0;
		end else if (cnt_reg == 16'h0000) begin
			cnt_reg <= rate_divisor - 16'h0001; // RULE_18
			tick_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
			tick_reg <= 1'b0;
		end
	end
endmodule // asp_rate_gen

// ### logic/asp_rx_core.v
// Receiver: line synchroniser, start detect, centre sampling
`include "asp_map.vh"
module asp_rx_core (
	input wire pclk,
	input wire presetn,
	input wire enable,
	input wire tick16,
	input wire extra_bit,
	input wire rxd,
	output reg [7:0] rx_byte_reg,
	output reg rx_ninth_reg,
	output reg rx_done_reg,
	output reg rx_frame_err_reg
);
	localparam ST_IDLE = 3'd0;
	localparam ST_START = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_EXTRA = 3'd3;
	localparam ST_STOP = 3'd4;
	reg s1_reg, s2_reg, s3_reg, line_reg;
	reg [2:0] state_reg;
	reg [3:0] ovs_reg;
	reg [2:0] bitn_reg;
	////////////////////////////////////////////////////////////////
	// Three-stage synchroniser, level accepted when stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			line_reg <= 1'b1;
		end else begin
			s1_reg <= rxd;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				line_reg <= s3_reg;
		end
	end
	////////////////////////////////////////////////////////////////
	// Frame state machine at sixteen samples per bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			ovs_reg <= 4'h0;
			bitn_reg <= 3'd0;
			rx_byte_reg <= 8'h00;
			rx_ninth_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			rx_frame_err_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			if (!enable) begin
				state_reg <= ST_IDLE;
			end else begin
				case (state_reg)
				ST_IDLE: begin
					ovs_reg <= 4'h0;
					bitn_reg <= 3'd0;
					if (!line_reg)
						state_reg <= ST_START; // RULE_21
				end
				ST_START: if (tick16) begin
					ovs_reg <= ovs_reg + 4'h1;
					if (ovs_reg == `ASP_MID_LAST) begin
						ovs_reg <= 4'h0;
						state_reg <= line_reg ? ST_IDLE : ST_DATA; // RULE_21
					end
				end
				ST_DATA: if (tick16) begin
					ovs_reg <= ovs_reg + 4'h1;
					if (ovs_reg == `ASP_OVS_LAST) begin
						rx_byte_reg <= {line_reg, rx_byte_reg[7:1]}; // RULE_20
						bitn_reg <= bitn_reg + 3'd1;
						if (bitn_reg == 3'd7)
							state_reg <= extra_bit ? ST_EXTRA : ST_STOP;
					end
				end
				ST_EXTRA: if (tick16) begin
					ovs_reg <= ovs_reg + 4'h1;
					if (ovs_reg == `ASP_OVS_LAST) begin
						rx_ninth_reg <= line_reg;
						state_reg <= ST_STOP;
					end
				end
				ST_STOP: if (tick16) begin
					ovs_reg <= ovs_reg + 4'h1;
					if (ovs_reg == `ASP_OVS_LAST) begin
						if (!extra_bit)
							rx_ninth_reg <= 1'b0;
						rx_frame_err_reg <= ~line_reg;
						rx_done_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // asp_rx_core

// ### logic/asp_serial_port.v
// Serial port top: APB registers, transmitter, receive filtering, timer
`include "asp_map.vh"
// Function
// RULE_01 - Empty holding register plus enable raises transmit request
// RULE_02 - Written byte moves to shifter automatically
// RULE_03 - Marker bit sent as ninth bit
// RULE_04 - Software clears transmit request after service
// RULE_05 - Data-available flag set on valid byte
// RULE_06 - Ninth bit handling follows scheme field
// RULE_07 - Receive interrupt covers data and errors
// RULE_08 - Option: interrupt on data+errors or errors
// RULE_09 - Two-bit field selects address matching scheme
// RULE_10 - Automatic schemes compare against address register
// RULE_11 - Parity only outside multiprocessor mode
// RULE_12 - Control bit enables clear-to-send flow control
// RULE_13 - Generator uses 16-bit divisor from two bytes
// RULE_14 - Bit rate is clock over sixteen times divisor
// RULE_15 - Port disabled when both enables zero
// RULE_16 - Disabled port lets generator act as timer
// RULE_17 - Timer control bit enables timer and interrupt
// RULE_18 - Timer interval is clock period times divisor
// RULE_19 - Control registers changed only while disabled
// RULE_20 - Frame: start, eight bits lsb first, extra, stop
// RULE_21 - Sixteen-times sampling; reading data clears flag
module asp_serial_port (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_reg,
	output reg pready_reg,
	output reg pslverr_reg,
	input wire rxd,
	input wire cts_n,
	output reg txd_reg,
	output reg tx_irq_reg,
	output reg rx_irq_reg,
	output reg timer_irq_reg
);
	localparam TX_IDLE = 3'd0;
	localparam TX_START = 3'd1;
	localparam TX_DATA = 3'd2;
	localparam TX_EXTRA = 3'd3;
	localparam TX_STOP = 3'd4;
	reg [7:0] port_control_first;
	reg [7:0] port_control_second;
	reg [7:0] addr_cmp_reg;
	reg [15:0] rate_divisor;
	reg [7:0] thr_reg;
	reg thr_full_reg;
	reg [7:0] rx_data_reg;
	reg rx_byte_available;
	reg rx_ninth_seen_reg;
	reg par_err_reg, frm_err_reg, ovr_err_reg;
	reg mp_selected_reg;
	reg timer_flag_reg;
	reg c1_reg, c2_reg, c3_reg, cts_lvl_reg;
	reg [2:0] tx_state_reg;
	reg [3:0] tx_ovs_reg;
	reg [2:0] tx_bitn_reg;
	reg [7:0] tx_sh_reg;
	reg tx_extra_reg;
	wire tx_enable_bit = port_control_first[`ASP_C0_TXEN];
	wire rx_enable = port_control_first[`ASP_C0_REN];
	wire cts_flow_en = port_control_first[`ASP_C0_CTSE];
	wire mp_en = port_control_second[`ASP_C1_MPEN];
	wire par_en = port_control_first[`ASP_C0_PEN] & ~mp_en; // RULE_11
	wire par_odd = port_control_first[`ASP_C0_PODD];
	wire [1:0] addr_match_scheme_sel = port_control_second[`ASP_C1_SCHEME_HI:`ASP_C1_SCHEME_LO];
	wire tx_address_marker_bit = port_control_second[`ASP_C1_MARK];
	wire rate_timer_enable = port_control_second[`ASP_C1_TMREN];
	wire port_on = rx_enable | tx_enable_bit; // RULE_15
	wire timer_mode = ~port_on & rate_timer_enable; // RULE_16
	wire extra_bit = mp_en | par_en;
	wire tick16;
	wire [7:0] rx_byte;
	wire rx_ninth, rx_done, rx_ferr;
	wire acc;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire [4:0] off = paddr[4:0];
	////////////////////////////////////////////////////////////////
	// Address decode, shared by read mux and error answer
	function mapped;
		input [31:0] a;
		begin
			mapped = (a[31:5] == 27'h0) && (a[1:0] == 2'b00);
		end
	endfunction
	// Unmapped accesses neither write nor clear flags
	assign acc = psel & penable & pready_reg & mapped(paddr);
	////////////////////////////////////////////////////////////////
	// Rate generator and receiver
	asp_rate_gen u_rate (
		.pclk(pclk),
		.presetn(presetn),
		.run(port_on | rate_timer_enable), // RULE_17
		.rate_divisor(rate_divisor), // RULE_14
		.tick_reg(tick16)
	);
	asp_rx_core u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.enable(rx_enable),
		.tick16(tick16 & port_on),
		.extra_bit(extra_bit),
		.rxd(rxd),
		.rx_byte_reg(rx_byte),
		.rx_ninth_reg(rx_ninth),
		.rx_done_reg(rx_done),
		.rx_frame_err_reg(rx_ferr)
	);
	////////////////////////////////////////////////////////////////
	// Clear-to-send synchroniser
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c1_reg <= 1'b1;
			c2_reg <= 1'b1;
			c3_reg <= 1'b1;
			cts_lvl_reg <= 1'b1;
		end else begin
			c1_reg <= cts_n;
			c2_reg <= c1_reg;
			c3_reg <= c2_reg;
			if (c2_reg == c3_reg)
				cts_lvl_reg <= c3_reg;
		end
	end
	////////////////////////////////////////////////////////////////
	// Receive acceptance by scheme and parity check
	reg accept;
	reg sel_next;
	reg perr;
	always @* begin
		accept = 1'b1;
		sel_next = mp_selected_reg;
		perr = par_en & ((^rx_byte) ^ rx_ninth ^ par_odd); // RULE_11
		if (mp_en) begin
			case (addr_match_scheme_sel) // RULE_09
			`ASP_MP_ALL: accept = 1'b1;
			`ASP_MP_ADDR_ONLY: accept = rx_ninth;
			`ASP_MP_MATCH: begin
				if (rx_ninth)
					sel_next = (rx_byte == addr_cmp_reg); // RULE_10
				accept = ~rx_ninth & mp_selected_reg;
			end
			`ASP_MP_MATCH_KEEP: begin
				if (rx_ninth)
					sel_next = (rx_byte == addr_cmp_reg); // RULE_10
				accept = rx_ninth ? sel_next : mp_selected_reg;
			end
			default: accept = 1'b1;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// Register writes, receive flags; hardware set wins over read clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_control_first <= `ASP_CTL0_RST;
			port_control_second <= `ASP_CTL1_RST;
			addr_cmp_reg <= `ASP_ADDR_RST;
			rate_divisor <= `ASP_DIV_RST;
			rx_data_reg <= 8'h00;
			rx_byte_available <= 1'b0;
			rx_ninth_seen_reg <= 1'b0;
			par_err_reg <= 1'b0;
			frm_err_reg <= 1'b0;
			ovr_err_reg <= 1'b0;
			mp_selected_reg <= 1'b0;
			timer_flag_reg <= 1'b0;
		end else begin
			if (wr) begin
				case (off)
				`ASP_OFF_CTL0: port_control_first <= pwdata[7:0];
				`ASP_OFF_CTL1: port_control_second <= pwdata[7:0];
				`ASP_OFF_ADDR: addr_cmp_reg <= pwdata[7:0];
				`ASP_OFF_DIVH: rate_divisor[15:8] <= pwdata[7:0]; // RULE_13
				`ASP_OFF_DIVL: rate_divisor[7:0] <= pwdata[7:0]; // RULE_13
				default: ;
				endcase
			end
			if (rd && off == `ASP_OFF_DATA) begin
				rx_byte_available <= 1'b0; // RULE_21
				par_err_reg <= 1'b0;
				frm_err_reg <= 1'b0;
				ovr_err_reg <= 1'b0;
			end
			if (wr && off == `ASP_OFF_IRQ && pwdata[2])
				timer_flag_reg <= 1'b0;
			if (tick16 && timer_mode)
				timer_flag_reg <= 1'b1; // RULE_16
			if (rx_done) begin
				mp_selected_reg <= sel_next; // RULE_06
				if (accept) begin
					rx_data_reg <= rx_byte; // RULE_06
					rx_ninth_seen_reg <= rx_ninth;
					rx_byte_available <= 1'b1; // RULE_05
					par_err_reg <= perr;
					frm_err_reg <= rx_ferr;
					if (rx_byte_available && !(rd && off == `ASP_OFF_DATA))
						ovr_err_reg <= 1'b1;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Transmitter: holding register, shifter, flow control
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_reg <= 8'h00;
			thr_full_reg <= 1'b0;
			tx_state_reg <= TX_IDLE;
			tx_ovs_reg <= 4'h0;
			tx_bitn_reg <= 3'd0;
			tx_sh_reg <= 8'h00;
			tx_extra_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			if (wr && off == `ASP_OFF_DATA) begin
				thr_reg <= pwdata[7:0];
				thr_full_reg <= 1'b1;
			end
			if (!tx_enable_bit) begin
				tx_state_reg <= TX_IDLE;
				txd_reg <= 1'b1; // RULE_20
			end else begin
				if (tick16)
					tx_ovs_reg <= tx_ovs_reg + 4'h1;
				case (tx_state_reg)
				TX_IDLE: begin
					txd_reg <= 1'b1;
					if (thr_full_reg && (!cts_flow_en || !cts_lvl_reg)) begin // RULE_12
						tx_sh_reg <= thr_reg; // RULE_02
						tx_extra_reg <= mp_en ? tx_address_marker_bit :
							((^thr_reg) ^ par_odd); // RULE_03
						thr_full_reg <= 1'b0;
						tx_ovs_reg <= 4'h0;
						tx_bitn_reg <= 3'd0;
						tx_state_reg <= TX_START;
						txd_reg <= 1'b0; // RULE_20
					end
				end
				TX_START: if (tick16 && tx_ovs_reg == `ASP_OVS_LAST) begin
					txd_reg <= tx_sh_reg[0];
					tx_state_reg <= TX_DATA;
				end
				TX_DATA: if (tick16 && tx_ovs_reg == `ASP_OVS_LAST) begin
					tx_bitn_reg <= tx_bitn_reg + 3'd1;
					tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
					if (tx_bitn_reg == 3'd7) begin
						txd_reg <= extra_bit ? tx_extra_reg : 1'b1; // RULE_03
						tx_state_reg <= extra_bit ? TX_EXTRA : TX_STOP;
					end else begin
						txd_reg <= tx_sh_reg[1]; // RULE_20
					end
				end
				TX_EXTRA: if (tick16 && tx_ovs_reg == `ASP_OVS_LAST) begin
					txd_reg <= 1'b1;
					tx_state_reg <= TX_STOP;
				end
				TX_STOP: if (tick16 && tx_ovs_reg == `ASP_OVS_LAST)
					tx_state_reg <= TX_IDLE;
				default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Interrupt request outputs
	wire err_any = par_err_reg | frm_err_reg | ovr_err_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq_reg <= 1'b0;
			rx_irq_reg <= 1'b0;
			timer_irq_reg <= 1'b0;
		end else begin
			tx_irq_reg <= port_control_second[`ASP_C1_TIE] & ~thr_full_reg & tx_enable_bit; // RULE_01
			rx_irq_reg <= port_control_second[`ASP_C1_RIE] &
				(port_control_second[`ASP_C1_ERRONLY] ? err_any : (err_any | rx_byte_available)); // RULE_07 RULE_08
			timer_irq_reg <= timer_flag_reg; // RULE_17
		end
	end
	////////////////////////////////////////////////////////////////
	// APB answer: one access cycle, no wait states
	reg [7:0] rmux;
	always @* begin
		case (off)
		`ASP_OFF_DATA: rmux = rx_data_reg;
		`ASP_OFF_STAT: rmux = {cts_lvl_reg, rx_ninth_seen_reg, ovr_err_reg, frm_err_reg,
			par_err_reg, tx_state_reg == TX_IDLE, ~thr_full_reg, rx_byte_available};
		`ASP_OFF_CTL0: rmux = port_control_first;
		`ASP_OFF_CTL1: rmux = port_control_second;
		`ASP_OFF_ADDR: rmux = addr_cmp_reg;
		`ASP_OFF_DIVH: rmux = rate_divisor[15:8];
		`ASP_OFF_DIVL: rmux = rate_divisor[7:0];
		`ASP_OFF_IRQ: rmux = {5'h00, timer_flag_reg, rx_irq_reg, tx_irq_reg};
		default: rmux = 8'h00;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel & ~penable;
			pslverr_reg <= psel & ~penable & ~mapped(paddr);
			if (psel && !penable && !pwrite)
				prdata_reg <= mapped(paddr) ? {24'h000000, rmux} : 32'h00000000;
		end
	end
endmodule // asp_serial_port

// ### dv/asp_remote_uart.sv
// Remote serial device model on the line side of the port
module asp_remote_uart (
	input wire pclk,
	input wire txd,
	output logic rxd,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int bc = 32;
	logic ep = 1'b0;
	logic [9:0] f;
	logic [9:0] got [$];
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Capture: start edge, centre sampling, lsb first
	always begin
		@(negedge txd);
		f = 10'h3ff;
		repeat (bc / 2) @(posedge pclk);
		for (int i = 0; i < (ep ? 10 : 9); i++) begin
			repeat (bc) @(posedge pclk);
			f[i] = txd;
		end
		got.push_back(f);
	end
	task automatic bit_out(input logic v);
		rxd <= v;
		repeat (bc) @(posedge pclk);
	endtask
	// Frame: start, data lsb first, optional extra bit, stop, idle bit
	task automatic send(input logic [7:0] b, input logic [1:0] ext, input logic stp);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(b[i]);
		end
		if (ext[1]) begin
			bit_out(ext[0]);
		end
		bit_out(stp);
		bit_out(1'b1);
	endtask
endmodule // asp_remote_uart

// ### dv/asp_serial_port_assertions.sv
// Port-level assertions for the serial port
`include "asp_map.vh"
module asp_serial_port_assertions (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata_reg,
	input wire pready_reg,
	input wire pslverr_reg,
	input wire rxd,
	input wire cts_n,
	input wire txd_reg,
	input wire tx_irq_reg,
	input wire rx_irq_reg,
	input wire timer_irq_reg
);
	reg [7:0] ctl0_reg;
	reg [7:0] ctl1_reg;
	wire wr_done = psel && penable && pready_reg && pwrite && paddr[31:5] == 27'h0;
	// Shadow of the two control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl0_reg <= 8'h00;
			ctl1_reg <= 8'h00;
		end else if (wr_done && paddr[4:0] == `ASP_OFF_CTL0) begin
			ctl0_reg <= pwdata[7:0];
		end else if (wr_done && paddr[4:0] == `ASP_OFF_CTL1) begin
			ctl1_reg <= pwdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (psel && !penable |=> pready_reg ##1 !pready_reg)
		else $error("pready not a one-cycle answer");
	unmapped_err_a: assert property (psel && penable && (paddr[31:5] != 27'h0 || paddr[1:0] != 2'h0)
		|-> pslverr_reg && (pwrite || prdata_reg == 32'h0)) else $error("unmapped access not refused");
	tx_irq_gate_a: assert property ((!ctl1_reg[0]) [*3] |-> !tx_irq_reg)
		else $error("tx irq while disabled");
	rx_irq_gate_a: assert property ((!ctl1_reg[1]) [*3] |-> !rx_irq_reg)
		else $error("rx irq while disabled");
	tx_needs_en_a: assert property ($fell(txd_reg) |-> ctl0_reg[7])
		else $error("frame started without tx enable");
	cts_hold_a: assert property ((ctl0_reg[5] && cts_n) [*8] |-> !$fell(txd_reg))
		else $error("frame started while cts inactive");
	timer_idle_a: assert property ($rose(timer_irq_reg) |-> ctl0_reg[7:6] == 2'b00 && ctl1_reg[3])
		else $error("timer irq while port enabled");
	start_len_a: assert property ($fell(txd_reg) |=> (!txd_reg) [*8])
		else $error("start bit too short");
	high_len_a: assert property ($rose(txd_reg) |=> txd_reg [*8])
		else $error("high bit too short");
	cover property ($fell(txd_reg));
	cover property ($rose(rx_irq_reg));
	cover property ($rose(timer_irq_reg));
endmodule // asp_serial_port_assertions

bind asp_serial_port asp_serial_port_assertions i_asp_serial_port_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
	.pslverr_reg(pslverr_reg), .rxd(rxd), .cts_n(cts_n), .txd_reg(txd_reg),
	.tx_irq_reg(tx_irq_reg), .rx_irq_reg(rx_irq_reg), .timer_irq_reg(timer_irq_reg));

// ### dv/asp_serial_port_tb.sv
// Testbench for the serial port: APB tasks and line scenarios
`include "asp_map.vh"
module asp_serial_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC = 32;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata_reg;
	wire pready_reg, pslverr_reg, rxd, cts_n, txd_reg, tx_irq_reg, rx_irq_reg, timer_irq_reg;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int k, t0;
	logic err_q;
	logic [31:0] r;
	logic [3:0] mask [4] = '{4'h1, 4'h5, 4'h8, 4'hc};
	logic [7:0] seq [4] = '{8'h41, 8'h10, 8'h42, 8'h11};
	logic [3:0] nine = 4'h5;
	asp_serial_port i_asp_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
		.pslverr_reg(pslverr_reg), .rxd(rxd), .cts_n(cts_n), .txd_reg(txd_reg), .tx_irq_reg(tx_irq_reg),
		.rx_irq_reg(rx_irq_reg), .timer_irq_reg(timer_irq_reg));
	asp_remote_uart i_asp_remote_uart (.pclk(pclk), .txd(txd_reg), .rxd(rxd), .cts_n(cts_n));
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {27'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_reg !== 1'b1);
		r = prdata_reg;
		err_q = pslverr_reg;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
		xfer(1'b1, `ASP_OFF_CTL0, 8'h00);
		xfer(1'b1, `ASP_OFF_CTL1, c1);
		xfer(1'b1, `ASP_OFF_CTL0, c0);
	endtask
	task automatic poll();
		k = 0;
		do begin
			xfer(1'b0, `ASP_OFF_STAT, 8'h00);
			k++;
		end while (r[0] !== 1'b1 && k < 20);
	endtask
	task automatic getf(input logic [9:0] exp);
		k = 0;
		while (i_asp_remote_uart.got.size() == 0 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		chk("tx_frame", {22'h0, (k < 2000) ? i_asp_remote_uart.got.pop_front() : 10'h0}, {22'h0, exp});
		repeat (BC) @(posedge pclk);
	endtask
	task automatic txone(input logic [7:0] c1, c0, d, input logic e, input logic [9:0] exp);
		cfg(c1, c0);
		i_asp_remote_uart.ep = e;
		xfer(1'b1, `ASP_OFF_DATA, d);
		getf(exp);
	endtask
	task automatic waitirq(input logic v);
		k = 0;
		while (timer_irq_reg !== v && k < 1000) begin
			@(posedge pclk);
			k++;
		end
		chk("timer_irq", timer_irq_reg, v);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `ASP_OFF_CTL1, 8'h00);
		chk("ctl1", r, 32'h0);
		xfer(1'b0, `ASP_OFF_DIVL, 8'h00);
		chk("divl", r, 32'h2);
		xfer(1'b1, `ASP_OFF_STAT, 8'hff);
		xfer(1'b0, `ASP_OFF_STAT, 8'h00);
		chk("stat", r & 32'h7, 32'h6);
		xfer(1'b0, 5'h1e, 8'h00);
		chk("unmapped", {r[30:0], err_q}, 32'h1);
		// Back-to-back bytes and transmit request
		cfg(8'h01, 8'h80);
		xfer(1'b0, `ASP_OFF_STAT, 8'h00);
		chk("tx_irq", tx_irq_reg, 1'b1);
		xfer(1'b1, `ASP_OFF_DATA, 8'ha5);
		xfer(1'b1, `ASP_OFF_DATA, 8'h3c);
		getf({2'b11, 8'ha5});
		getf({2'b11, 8'h3c});
		cfg(8'h00, 8'h80);
		xfer(1'b0, `ASP_OFF_STAT, 8'h00);
		chk("tx_irq_off", tx_irq_reg, 1'b0);
		// Parity, marker, and parity ignored in multiprocessor mode
		txone(8'h00, 8'h98, 8'h5a, 1'b1, {2'b11, 8'h5a});
		txone(8'h00, 8'h90, 8'h5a, 1'b1, {2'b10, 8'h5a});
		txone(8'h90, 8'h80, 8'h33, 1'b1, {2'b11, 8'h33});
		txone(8'h80, 8'h98, 8'h35, 1'b1, {2'b10, 8'h35});
		// Flow control defers the frame until clear-to-send
		i_asp_remote_uart.cts_n <= 1'b1;
		txone(8'h00, 8'h80, 8'h00, 1'b0, {2'b11, 8'h00});
		cfg(8'h00, 8'ha0);
		xfer(1'b1, `ASP_OFF_DATA, 8'h96);
		repeat (100) @(posedge pclk);
		chk("cts_hold", {txd_reg, i_asp_remote_uart.got.size() == 0}, 2'b11);
		i_asp_remote_uart.cts_n <= 1'b0;
		getf({2'b11, 8'h96});
		// Reception, data interrupt, errors-only option
		cfg(8'h02, 8'h40);
		i_asp_remote_uart.send(8'hc3, 2'b00, 1'b1);
		poll();
		chk("avail", {r[0], rx_irq_reg}, 2'b11);
		xfer(1'b0, `ASP_OFF_DATA, 8'h00);
		chk("rx_data", r, 32'hc3);
		xfer(1'b0, `ASP_OFF_STAT, 8'h00);
		chk("avail_clr", r[0], 1'b0);
		cfg(8'h06, 8'h40);
		i_asp_remote_uart.send(8'h77, 2'b00, 1'b1);
		poll();
		chk("err_only", {r[0], rx_irq_reg}, 2'b10);
		xfer(1'b0, `ASP_OFF_DATA, 8'h00);
		i_asp_remote_uart.send(8'h55, 2'b00, 1'b0);
		poll();
		chk("frame_err", {r[4], rx_irq_reg}, 2'b11);
		xfer(1'b0, `ASP_OFF_DATA, 8'h00);
		xfer(1'b0, `ASP_OFF_STAT, 8'h00);
		chk("err_clr", rx_irq_reg, 1'b0);
		// Address matching schemes
		xfer(1'b1, `ASP_OFF_ADDR, 8'h42);
		for (int s = 0; s < 4; s++) begin
			cfg({1'b1, s[1:0], 5'h00}, 8'h40);
			for (int i = 0; i < 4; i++) begin
				i_asp_remote_uart.send(seq[i], {1'b1, nine[i]}, 1'b1);
				poll();
				chk("mp_avail", r[0], mask[s][i] | (s == 0));
				if (r[0] === 1'b1) begin
					chk("mp_ninth", r[6], nine[i]);
					xfer(1'b0, `ASP_OFF_DATA, 8'h00);
					chk("mp_data", r, {24'h0, seq[i]});
				end
			end
		end
		// Generator as interval timer
		xfer(1'b1, `ASP_OFF_DIVH, 8'h00);
		xfer(1'b1, `ASP_OFF_DIVL, 8'h10);
		cfg(8'h08, 8'h00);
		waitirq(1'b1);
		t0 = cyc;
		xfer(1'b1, `ASP_OFF_IRQ, 8'h04);
		waitirq(1'b0);
		waitirq(1'b1);
		chk("timer_period", cyc - t0, 32'd16);
		conclude();
	end
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		conclude();
	end
endmodule // asp_serial_port_tb
